// ---- core/irq_evt_cmd.sv ----
// decoder for interrupt control, handler return, customer functions and
// position reached event requests
// assumes frames, program instructions and motion events share sys_clk
`timescale 1ns/1ns
module irq_evt_cmd
  import irq_evt_pkg::*;
(
  input  wire logic                  sys_clk,       // system clock
  input  wire logic                  reset_n,       // async reset, low
  input  wire cmd_frame_s            host_frame,    // host command frame
  input  wire logic                  host_valid,    // host frame strobe
  input  wire cmd_frame_s            prog_instr,    // stored program instruction
  input  wire logic                  prog_valid,    // program instruction strobe
  input  wire logic                  irq_entry,     // handler entry pulse
  input  wire ctx_s                  entry_ctx,     // context at entry
  input  wire logic                  mvp_valid,     // move-to-position issued
  input  wire logic [NUM_MOTOR-1:0]  mvp_mask,      // motors of that move
  input  wire logic [NUM_MOTOR-1:0]  reached,       // target reached pulses
  input  wire logic [IRQ_W-1:0]      vec_sel,       // vector table index
  output logic [VEC_W-1:0]           vec_addr,      // selected vector
  output logic [NUM_IRQ-1:0]         irq_enable,    // per-source enables
  output logic                       irq_glob_en,   // global enable
  output logic                       restore_valid, // context restore pulse
  output ctx_s                       restore_ctx,   // restored context
  output logic                       uf_valid,      // customer function pulse
  output cmd_frame_s                 uf_frame,      // customer function frame
  output logic                       reply_valid,   // reply pulse
  output reply_s                     reply          // reply frame
);

  typedef struct packed {
    logic [NUM_IRQ-1:0]             irq_en;
    logic                           glob_en;
    logic [NUM_IRQ-1:0][VEC_W-1:0]  vec;
    logic [VEC_W-1:0]               vec_out;
    ctx_s                           saved;
    ctx_s                           rest;
    logic                           rest_v;
    cmd_frame_s                     uf;
    logic                           uf_v;
    logic [NUM_MOTOR-1:0]           armed;
    logic                           persist;
    logic [NUM_MOTOR-1:0]           pending;
    logic [NUM_MOTOR-1:0]           done;
    reply_s                         rep;
    logic                           rep_v;
  } core_s;

  core_s      state_reg;
  core_s      state_next;
  logic       sum_ok;
  cmd_frame_s cmd;
  logic       cmd_v;
  logic       from_host;

  frame_sum_check u_sum (
    .frame  (host_frame),
    .sum_ok (sum_ok)
  );

  // build one reply frame with its checksum
  function automatic reply_s make_reply(input logic [7:0] st, input logic [7:0] op,
                                        input logic [31:0] val);
    reply_s r;
    r.reply_addr  = HOST_ADDR;
    r.module_addr = MODULE_ADDR;
    r.status      = st;
    r.opcode      = op;
    r.value       = val;
    r.csum        = sum8({HOST_ADDR, MODULE_ADDR, st, op, val});
    return r;
  endfunction

  // host frames win over program instructions in the same cycle
  always_comb
  begin
    from_host = host_valid && (host_frame.addr == MODULE_ADDR);
    cmd       = from_host ? host_frame : prog_instr;
    cmd_v     = from_host || prog_valid;
  end

  // next state
  always_comb
  begin
    logic       host_ok;
    logic [7:0] n;
    logic [NUM_MOTOR-1:0] hit;
    host_ok    = 1'b0;
    n          = 8'h00;
    hit        = '0;
    state_next = state_reg;
    state_next.rest_v = 1'b0;
    state_next.uf_v   = 1'b0;
    state_next.rep_v  = 1'b0;
    state_next.vec_out = state_reg.vec[vec_sel];
    n = cmd.ctype;

    // save context on handler entry
    if (irq_entry)
      state_next.saved = entry_ctx;

    // pending motors that reach become due; a move in the same cycle sets its motor pending again if armed
    hit = reached & state_reg.pending;
    state_next.pending = state_reg.pending & ~hit;

    // moves pick up the armed mask; a new request below wins
    if (mvp_valid)
    begin
      state_next.pending = state_next.pending | (mvp_mask & state_reg.armed);
      if (!state_reg.persist && |(mvp_mask & state_reg.armed))
        state_next.armed = '0;
    end

    if (from_host && !sum_ok)
    begin
      state_next.rep   = make_reply(ST_BAD_SUM, cmd.opcode, 32'h0000_0000);
      state_next.rep_v = 1'b1;
    end
    else if (cmd_v)
    begin
      host_ok = from_host;
      case (cmd.opcode)
        OP_IRQ_MASK:
        begin
          if (n == TYPE_GLOBAL)
            state_next.glob_en = 1'b0;
          else if (n < 8'(NUM_IRQ))
            state_next.irq_en[n[IRQ_W-1:0]] = 1'b0;
        end
        OP_IRQ_UNMASK:
        begin
          if (n == TYPE_GLOBAL)
            state_next.glob_en = 1'b1;
          else if (n < 8'(NUM_IRQ))
            state_next.irq_en[n[IRQ_W-1:0]] = 1'b1;
        end
        OP_VEC_DEF:
        begin
          if (n < 8'(NUM_IRQ))
            state_next.vec[n[IRQ_W-1:0]] = cmd.value[VEC_W-1:0];
        end
        OP_HND_RET:
        begin
          state_next.rest   = state_reg.saved;
          state_next.rest_v = 1'b1;
        end
        OP_POS_EVT:
        begin
          if (from_host)
          begin
            state_next.armed   = cmd.value[NUM_MOTOR-1:0];
            state_next.persist = (n == TYPE_PERSIST);
          end
        end
        default:
        begin
          if (cmd.opcode >= OP_UF_FIRST && cmd.opcode <= OP_UF_LAST)
          begin
            state_next.uf   = cmd;
            state_next.uf_v = 1'b1;
          end
          else
            host_ok = 1'b0;
        end
      endcase
      if (host_ok)
      begin
        state_next.rep   = make_reply(ST_OK, cmd.opcode,
                                      (cmd.opcode == OP_POS_EVT) ? cmd.value : 32'h0000_0000);
        state_next.rep_v = 1'b1;
      end
    end

    // delayed reply when the line is free
    if (!state_next.rep_v && |state_reg.done)
    begin
      state_next.rep   = make_reply(ST_POS_EVT, OP_POS_EVT,
                                    32'(state_reg.done));
      state_next.rep_v = 1'b1;
      state_next.done  = hit;
    end
    else
      state_next.done  = state_reg.done | hit;
  end

  // state register
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_reg         <= '0;
      state_reg.irq_en  <= RST_IRQ_EN;
      state_reg.glob_en <= RST_GLOB_EN;
      state_reg.vec     <= {NUM_IRQ{RST_VEC}};
    end
    else
      state_reg <= state_next;
  end

  // outputs straight from the state register
  assign vec_addr      = state_reg.vec_out;
  assign irq_enable    = state_reg.irq_en;
  assign irq_glob_en   = state_reg.glob_en;
  assign restore_valid = state_reg.rest_v;
  assign restore_ctx   = state_reg.rest;
  assign uf_valid      = state_reg.uf_v;
  assign uf_frame      = state_reg.uf;
  assign reply_valid   = state_reg.rep_v;
  assign reply         = state_reg.rep;

endmodule

// ---- core/irq_evt_pkg.sv ----
// shared types, opcodes, status codes and reset values for the interrupt
// and position event command decoder; all logic runs on one clock
package irq_evt_pkg;

  localparam int        NUM_IRQ   = 16;   // interrupt sources
  localparam int        NUM_MOTOR = 8;    // motors covered by the event mask
  localparam int        VEC_W     = 32;   // handler entry address width
  localparam int        IRQ_W     = $clog2(NUM_IRQ);

  // command opcodes
  localparam logic [7:0] OP_IRQ_UNMASK = 8'h19;
  localparam logic [7:0] OP_IRQ_MASK   = 8'h1A;
  localparam logic [7:0] OP_VEC_DEF    = 8'h25;
  localparam logic [7:0] OP_HND_RET    = 8'h26;
  localparam logic [7:0] OP_UF_FIRST   = 8'h40;
  localparam logic [7:0] OP_UF_LAST    = 8'h47;
  localparam logic [7:0] OP_POS_EVT    = 8'h8A;

  // type field codes
  localparam logic [7:0] TYPE_GLOBAL   = 8'hFF;
  localparam logic [7:0] TYPE_ONESHOT  = 8'h00;
  localparam logic [7:0] TYPE_PERSIST  = 8'h01;

  // reply status codes
  localparam logic [7:0] ST_OK         = 8'h64;
  localparam logic [7:0] ST_POS_EVT    = 8'h80;
  localparam logic [7:0] ST_BAD_SUM    = 8'h01;

  // addresses
  localparam logic [7:0] MODULE_ADDR   = 8'h01;
  localparam logic [7:0] HOST_ADDR     = 8'h02;

  // reset values
  localparam logic               RST_GLOB_EN = 1'b0;
  localparam logic [NUM_IRQ-1:0] RST_IRQ_EN  = '0;
  localparam logic [VEC_W-1:0]   RST_VEC     = '0;

  typedef struct packed {
    logic [7:0]  addr;
    logic [7:0]  opcode;
    logic [7:0]  ctype;
    logic [7:0]  bank;
    logic [31:0] value;
    logic [7:0]  csum;
  } cmd_frame_s;

  typedef struct packed {
    logic [7:0]  reply_addr;
    logic [7:0]  module_addr;
    logic [7:0]  status;
    logic [7:0]  opcode;
    logic [31:0] value;
    logic [7:0]  csum;
  } reply_s;

  typedef struct packed {
    logic [31:0] acc;
    logic [31:0] xreg;
    logic [7:0]  flags;
    logic [31:0] pc;
  } ctx_s;

  // low eight bits of the sum of eight frame bytes
  function automatic logic [7:0] sum8(input logic [63:0] bytes);
    logic [7:0] s;
    s = 8'h00;
    for (int i = 0; i < 8; i++)
      s = s + bytes[i*8 +: 8];
    return s;
  endfunction

endpackage

// ---- core/frame_sum_check.sv ----
// checksum test for one incoming command frame
// assumes the frame is held stable while its valid is high
`timescale 1ns/1ns
module frame_sum_check
  import irq_evt_pkg::*;
(
  input  wire cmd_frame_s frame,    // frame under test
  output logic            sum_ok    // checksum matches
);

  // compare carried checksum with the sum of the first eight bytes
  assign sum_ok = (sum8(frame[71:8]) == frame.csum);

endmodule

// ---- dv/irq_evt_cmd_chk.sv ----
// checker for irq_evt_cmd, bound to its top ports
// assumes one clock and an active low reset
`timescale 1ns/1ns
module irq_evt_cmd_chk
  import irq_evt_pkg::*;
(
  input wire logic               sys_clk,       // clock
  input wire logic               reset_n,       // reset
  input wire logic               host_valid,    // host strobe
  input wire cmd_frame_s         prog_instr,    // program word
  input wire logic               prog_valid,    // program strobe
  input wire logic [NUM_IRQ-1:0] irq_enable,    // enables
  input wire logic               irq_glob_en,   // global enable
  input wire logic               restore_valid, // restore pulse
  input wire logic               uf_valid,      // customer pulse
  input wire logic               reply_valid,   // reply pulse
  input wire reply_s             reply          // reply frame
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // program word taken alone, decoded fields
  wire       pv     = prog_valid && !host_valid;
  wire [7:0] po     = prog_instr.opcode;
  wire [7:0] pt     = prog_instr.ctype;
  wire       pm     = pv && po == OP_IRQ_MASK;
  wire       pu     = pv && po == OP_IRQ_UNMASK;
  wire       pf     = po >= OP_UF_FIRST && po <= OP_UF_LAST;
  // reply kinds and the event reply format
  wire       rok    = reply_valid && reply.status == ST_OK;
  wire       revt   = reply_valid && reply.status == ST_POS_EVT;
  wire       evt_ok = reply.opcode == OP_POS_EVT && reply.value[31:8] == 24'h0;
  AST_GLOB_OFF: assert property (pm && pt == TYPE_GLOBAL |=> !irq_glob_en)
    else $error("global still on");
  AST_MASK_ONE: assert property (pm && pt < 8'h10 |=> !irq_enable[$past(pt)])
    else $error("source still on");
  AST_GLOB_ON: assert property (pu && pt == TYPE_GLOBAL |=> irq_glob_en)
    else $error("global still off");
  AST_RET: assert property (pv && po == OP_HND_RET |=> restore_valid)
    else $error("no restore");
  AST_UF: assert property (pv && pf |=> uf_valid)
    else $error("no customer pulse");
  AST_PROG_EVT: assert property (pv && po == OP_POS_EVT |=> !rok)
    else $error("program event replied");
  AST_EVT_FMT: assert property (revt |-> evt_ok)
    else $error("bad event reply");
  AST_OK_SRC: assert property (rok |-> $past(host_valid))
    else $error("reply without frame");
  COV_EVT: cover property (revt);
  COV_RET: cover property (restore_valid);
  COV_UF: cover property (uf_valid);
endmodule

bind irq_evt_cmd irq_evt_cmd_chk chk_u (.sys_clk(sys_clk), .reset_n(reset_n),
  .host_valid(host_valid), .prog_instr(prog_instr), .prog_valid(prog_valid),
  .irq_enable(irq_enable), .irq_glob_en(irq_glob_en), .restore_valid(restore_valid),
  .uf_valid(uf_valid), .reply_valid(reply_valid), .reply(reply));

// ---- dv/host_model.sv ----
// host side: issues command frames with checksum
// frames leave on the rising edge, strobe lasts one cycle
`timescale 1ns/1ns
module host_model
  import irq_evt_pkg::*;
(
  input  wire logic sys_clk,    // clock
  output cmd_frame_s host_frame, // frame to device
  output logic       host_valid  // frame strobe
);
  // idle lines at start
  initial
  begin
    host_frame = '0;
    host_valid = 1'b0;
  end
  // one frame; bad spoils the checksum
  task automatic send(input logic [7:0] op, ty, input logic [31:0] v, input logic bad);
    cmd_frame_s f;
    f = {MODULE_ADDR, op, ty, 8'h00, v, 8'h00};
    f.csum = (f.addr + op + ty + v[31:24] + v[23:16] + v[15:8] + v[7:0]) ^ {8{bad}};
    @(posedge sys_clk);
    host_frame <= f;
    host_valid <= 1'b1;
    @(posedge sys_clk);
    host_valid <= 1'b0;
    host_frame <= ~f; // stale frame not left on lines
  endtask
endmodule

// ---- dv/irq_evt_cmd_tb.sv ----
// testbench for irq_evt_cmd
// host frames from host_model, all other inputs from here
`timescale 1ns/1ns
module irq_evt_cmd_tb
  import irq_evt_pkg::*;
;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic host_valid, prog_valid = 1'b0, irq_entry = 1'b0, mvp_valid = 1'b0;
  logic irq_glob_en, restore_valid, uf_valid, reply_valid;
  cmd_frame_s host_frame, uf_frame, prog_instr = '0;
  ctx_s entry_ctx = '0, restore_ctx;
  logic [NUM_MOTOR-1:0] mvp_mask = '0, reached = '0;
  logic [IRQ_W-1:0] vec_sel = '0;
  logic [VEC_W-1:0] vec_addr;
  logic [NUM_IRQ-1:0] irq_enable;
  reply_s reply;
  int err_count = 0, check_count = 0, cyc = 0;
  // 10 MHz clock
  always #50 sys_clk = ~sys_clk;
  host_model host_u (.sys_clk(sys_clk), .host_frame(host_frame), .host_valid(host_valid));
  irq_evt_cmd dut_u (.sys_clk(sys_clk), .reset_n(reset_n), .host_frame(host_frame),
    .host_valid(host_valid), .prog_instr(prog_instr), .prog_valid(prog_valid),
    .irq_entry(irq_entry), .entry_ctx(entry_ctx), .mvp_valid(mvp_valid),
    .mvp_mask(mvp_mask), .reached(reached), .vec_sel(vec_sel), .vec_addr(vec_addr),
    .irq_enable(irq_enable), .irq_glob_en(irq_glob_en), .restore_valid(restore_valid),
    .restore_ctx(restore_ctx), .uf_valid(uf_valid), .uf_frame(uf_frame),
    .reply_valid(reply_valid), .reply(reply));
  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // hang guard
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      err_count++;
      close_out;
    end
  end
  task automatic check(input logic [63:0] seen, exp);
    check_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: %h expected %h", $time, seen, exp);
    end
  endtask
  // look for a reply pulse within six cycles
  task automatic wait_rep(output logic got);
    got = 1'b0;
    for (int i = 0; i < 6 && !got; i++)
    begin
      #1 got = reply_valid;
      if (!got) @(posedge sys_clk);
    end
  endtask
  task automatic rep(input logic [7:0] st, op, input logic [31:0] v);
    logic got;
    logic [7:0] cs;
    cs = HOST_ADDR + MODULE_ADDR + st + op + v[31:24] + v[23:16] + v[15:8] + v[7:0];
    wait_rep(got);
    check({got, reply.status, reply.opcode, reply.value}, {1'b1, st, op, v});
    check(reply.csum, cs);
  endtask
  task automatic none;
    logic got;
    wait_rep(got);
    check(got, 0);
  endtask
  task automatic prog(input logic [7:0] op, ty, input logic [31:0] v);
    @(posedge sys_clk);
    prog_instr <= {MODULE_ADDR, op, ty, 8'h00, v, 8'h00};
    prog_valid <= 1'b1;
    @(posedge sys_clk);
    prog_valid <= 1'b0;
    #1;
  endtask
  task automatic mv(input logic [7:0] m, r);
    @(posedge sys_clk);
    mvp_valid <= 1'b1;
    mvp_mask <= m;
    @(posedge sys_clk);
    mvp_valid <= 1'b0;
    reached <= r;
    @(posedge sys_clk);
    reached <= '0;
  endtask
  task automatic t_irq;
    host_u.send(OP_IRQ_UNMASK, TYPE_GLOBAL, 0, 1);
    rep(ST_BAD_SUM, OP_IRQ_UNMASK, 0);
    check(irq_glob_en, 0);
    host_u.send(OP_IRQ_UNMASK, TYPE_GLOBAL, 0, 0);
    rep(ST_OK, OP_IRQ_UNMASK, 0);
    host_u.send(OP_IRQ_UNMASK, 8'h03, 0, 0);
    rep(ST_OK, OP_IRQ_UNMASK, 0);
    check({irq_glob_en, irq_enable}, 17'h10008);
    host_u.send(OP_IRQ_MASK, 8'h03, 0, 0);
    rep(ST_OK, OP_IRQ_MASK, 0);
    check({irq_glob_en, irq_enable}, 17'h10000);
    host_u.send(OP_IRQ_MASK, TYPE_GLOBAL, 0, 0);
    rep(ST_OK, OP_IRQ_MASK, 0);
    check(irq_glob_en, 0);
  endtask
  // masks, customer function, vector, return and ignored event request, all from programs
  task automatic t_prog;
    prog(OP_IRQ_UNMASK, TYPE_GLOBAL, 0);
    prog(OP_IRQ_UNMASK, 8'h05, 0);
    check({irq_glob_en, irq_enable}, 17'h10020);
    prog(OP_IRQ_MASK, 8'h05, 0);
    prog(OP_IRQ_MASK, TYPE_GLOBAL, 0);
    check({irq_glob_en, irq_enable}, 17'h00000);
    prog(OP_UF_FIRST, 8'h00, 32'h0000_0007);
    check({uf_valid, uf_frame.opcode, uf_frame.value}, {1'b1, OP_UF_FIRST, 32'h7});
    prog(OP_VEC_DEF, 8'h02, 32'h32);
    prog(OP_VEC_DEF, 8'h02, 32'h50);
    @(posedge sys_clk);
    vec_sel <= 4'h2;
    repeat (2) @(posedge sys_clk);
    #1 check(vec_addr, 32'h50);
    @(posedge sys_clk);
    irq_entry <= 1'b1;
    entry_ctx <= {32'h1, 32'h2, 8'h3, 32'h44};
    @(posedge sys_clk);
    irq_entry <= 1'b0;
    prog(OP_HND_RET, TYPE_GLOBAL, 0);
    check({restore_valid, restore_ctx.acc, restore_ctx.pc}, {1'b1, 32'h1, 32'h44});
    check({restore_ctx.xreg, restore_ctx.flags}, {32'h2, 8'h3});
    prog(OP_POS_EVT, TYPE_PERSIST, 1);
    none;
    mv(8'h01, 8'h01);
    none;
  endtask
  task automatic t_uf;
    for (logic [7:0] op = OP_UF_FIRST; op <= OP_UF_LAST; op++)
    begin
      host_u.send(op, op, {24'h0, op}, 0);
      rep(ST_OK, op, 0);
      check({uf_valid, uf_frame.opcode, uf_frame.value}, {1'b1, op, 24'h0, op});
    end
  endtask
  task automatic t_evt;
    host_u.send(OP_POS_EVT, TYPE_ONESHOT, 32'h05, 0);
    rep(ST_OK, OP_POS_EVT, 32'h05);
    mv(8'h07, 8'h01);
    rep(ST_POS_EVT, OP_POS_EVT, 32'h01);
    mv(8'h07, 8'h01);
    none;
    host_u.send(OP_POS_EVT, TYPE_PERSIST, 32'h04, 0);
    rep(ST_OK, OP_POS_EVT, 32'h04);
    repeat (2)
    begin
      mv(8'h04, 8'h04);
      rep(ST_POS_EVT, OP_POS_EVT, 32'h04);
    end
  endtask
  // reset, then scenarios
  initial
  begin
    repeat (4) @(posedge sys_clk);
    reset_n <= 1'b1;
    t_irq;
    t_prog;
    t_uf;
    t_evt;
    close_out;
  end
endmodule
